// File: src/pmic_event_pkg.sv
package pmic_event_pkg;

  // ************************************************************
  // Register bus shape
  // ************************************************************
  localparam int DATA_W = 24;
  localparam int ADDR_W = 6;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS_FIRST = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_EVENT_MASK_FIRST = 6'h01;
  localparam logic [ADDR_W-1:0] OFS_LIVE_CONDITION_FIRST = 6'h02;
  localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS_SECOND = 6'h03;
  localparam logic [ADDR_W-1:0] OFS_EVENT_MASK_SECOND = 6'h04;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BIT_WATCHDOG_INPUT_RESET_FLAG = 5;
  localparam int BIT_BUTTON_SYSTEM_RESET_FLAG = 6;
  localparam int BIT_LOW_POWER_USB_BOOT_FLAG = 11;
  localparam int BIT_THERMAL_LOW_WARNING_FLAG = 12;
  localparam int BIT_THERMAL_HIGH_WARNING_FLAG = 13;
  localparam int BIT_SHORT_CIRCUIT_TRIP_FLAG = 16;
  localparam int BIT_BATTERY_REMOVAL_MASK = 22;
  localparam int BIT_WALL_CHARGER_FLAG = 21;
  localparam int BIT_CHARGER_ENABLED_LIVE = 7;
  localparam int BIT_B_SESSION_VALID_LIVE = 16;
  localparam int BIT_ID_FACTORY_LIVE = 4;

  // ************************************************************
  // Implemented bits and reset domains per register
  // ************************************************************
  localparam logic [DATA_W-1:0] FIRST_IMPL = 24'h39_7fff;
  localparam logic [DATA_W-1:0] FIRST_RTC_DOMAIN = 24'h00_00a0;
  localparam logic [DATA_W-1:0] FIRST_OFF_DOMAIN = 24'h01_1048;
  localparam logic [DATA_W-1:0] SECOND_IMPL = 24'hc1_ffff;
  localparam logic [DATA_W-1:0] SECOND_RTC_DOMAIN = 24'h00_0ee3;
  localparam logic [DATA_W-1:0] SECOND_OFF_DOMAIN = 24'h00_011c;
  localparam logic [DATA_W-1:0] LIVE_FIRST_IMPL = 24'h19_7ff8;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [DATA_W-1:0] RST_EVENT_FLAGS_FIRST = 24'h00_0000;
  localparam logic [DATA_W-1:0] RST_EVENT_MASK_FIRST = 24'hff_ffff;
  localparam logic [DATA_W-1:0] RST_EVENT_FLAGS_SECOND = 24'h00_0080;
  localparam logic [DATA_W-1:0] RST_EVENT_MASK_SECOND = 24'hff_f7ff;
  localparam logic [DATA_W-1:0] RST_READ_DATA = 24'h00_0000;

  // ************************************************************
  // Reset domain pins, in synchroniser order
  // ************************************************************
  localparam int DOMAIN_PINS = 3;
  localparam int PIN_EXTERNAL = 0;
  localparam int PIN_RTC = 1;
  localparam int PIN_OFF = 2;
  localparam logic [DOMAIN_PINS-1:0] RST_DOMAIN_PINS_N = 3'h0;

endpackage : pmic_event_pkg

// File: src/level_sync_2ff.sv
module level_sync_2ff #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ************************************************************
  // State
  // ************************************************************
  // The first stage is read only by the second stage, so a metastable
  // sample never reaches any logic.
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t state_r;
  sync_state_t state_nxt;

  always_comb
  begin
    state_nxt.meta = async_in;
    state_nxt.stable = state_r.meta;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      state_r.meta <= RESET_VALUE;
      state_r.stable <= RESET_VALUE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign sync_out = state_r.stable;

endmodule : level_sync_2ff

// File: src/pmic_event_status_mask_sense.sv
// Functional notes
// R1: Watchdog-input system reset latches second flags bit 5; write-one clears; RTC reset.
// R2: Button system reset latches second flags bit 6; write-one clears; RTC reset.
// R3: Short-circuit trip sets second flags bit 16; write-one or external reset clear.
// R4: Second mask bit 16 masks short-circuit trip; read-write; resets to one.
// R5: Low-power USB boot latches second flags bit 11; write-one clears; RTC reset.
// R6: Low-power USB boot mask, second mask bit 11, resets to zero.
// R7: Thermal low/high warnings latch second flags bits 12, 13; external reset.
// R8: First mask bit 21 masks wall charger flag; read-write; resets to one.
// R9: First live bit 7 shows charger enable; read-only; no reset.
// R10: First live bit 16 follows B-session validity continuously; no reset.
// R11: First live bit 4 follows ID factory condition; no reset.
// R12: Second mask bit 22 masks battery removal; read-write; external reset to one.
// R13: Live bits follow their inputs without latching.
// R14: Flag clears only on written one; written zero leaves it alone.
// R15: Off-state reset pulse forces off-domain bits to defaults.
// R16: External-reset-domain bits held at defaults while that pin is low.
// R17: Interrupt request high while any flag set with its mask clear.
// R18: Reserved and unused bits ignore writes and read their defaults.
module pmic_event_status_mask_sense (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire pmic_event_pkg::reg_req_t reg_req_in,
  input wire logic [pmic_event_pkg::DATA_W-1:0] first_event_in,
  input wire logic [pmic_event_pkg::DATA_W-1:0] second_event_in,
  input wire logic [pmic_event_pkg::DATA_W-1:0] live_condition_in,
  input wire logic external_reset_n_in,
  input wire logic rtc_power_on_reset_n_in,
  input wire logic off_state_reset_n_in,
  output logic [pmic_event_pkg::DATA_W-1:0] reg_rdata_out,
  output logic irq_out
);

  // ************************************************************
  // Local types
  // ************************************************************
  typedef struct packed {
    logic [pmic_event_pkg::DATA_W-1:0] flags_first;
    logic [pmic_event_pkg::DATA_W-1:0] mask_first;
    logic [pmic_event_pkg::DATA_W-1:0] flags_second;
    logic [pmic_event_pkg::DATA_W-1:0] mask_second;
    logic [pmic_event_pkg::DATA_W-1:0] rdata;
    logic irq;
  } evt_state_t;

  evt_state_t state_r;
  evt_state_t state_nxt;

  logic [pmic_event_pkg::DATA_W-1:0] live_sync;
  logic [pmic_event_pkg::DOMAIN_PINS-1:0] domain_pins_n_sync;
  logic [pmic_event_pkg::DATA_W-1:0] live_view;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic hit(
    input pmic_event_pkg::reg_req_t req,
    input logic [pmic_event_pkg::ADDR_W-1:0] ofs
  );
    hit = req.addr == ofs;
  endfunction : hit

  // Builds the set of bits that a reset domain currently holds, given the
  // implemented bits and the split between the three domains.
  function automatic logic [pmic_event_pkg::DATA_W-1:0] held_bits(
    input logic [pmic_event_pkg::DATA_W-1:0] impl,
    input logic [pmic_event_pkg::DATA_W-1:0] rtc_dom,
    input logic [pmic_event_pkg::DATA_W-1:0] off_dom,
    input logic [pmic_event_pkg::DOMAIN_PINS-1:0] pins_n
  );
    logic [pmic_event_pkg::DATA_W-1:0] ext_dom;
    ext_dom = impl & ~(rtc_dom | off_dom);
    held_bits = '0;
    if (!pins_n[pmic_event_pkg::PIN_EXTERNAL])
    begin
      held_bits = held_bits | ext_dom;
    end
    if (!pins_n[pmic_event_pkg::PIN_RTC])
    begin
      held_bits = held_bits | rtc_dom;
    end
    if (!pins_n[pmic_event_pkg::PIN_OFF])
    begin
      held_bits = held_bits | off_dom;
    end
  endfunction : held_bits

  // Write-one-to-clear flag update. The event is OR-ed in after the clear,
  // so an event in the same cycle as its clear survives.
  function automatic logic [pmic_event_pkg::DATA_W-1:0] flag_next(
    input logic [pmic_event_pkg::DATA_W-1:0] cur,
    input logic [pmic_event_pkg::DATA_W-1:0] evt,
    input logic clr_en,
    input logic [pmic_event_pkg::DATA_W-1:0] wdata,
    input logic [pmic_event_pkg::DATA_W-1:0] impl,
    input logic [pmic_event_pkg::DATA_W-1:0] dflt
  );
    logic [pmic_event_pkg::DATA_W-1:0] clr;
    clr = clr_en ? wdata : '0;
    flag_next = (((cur & ~clr) | evt) & impl) | (dflt & ~impl);
  endfunction : flag_next

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  // Live conditions and reset-domain pins come from outside this clock,
  // so they are seen two cycles late; a reset-domain pulse shorter than
  // one clock period may be missed.
  level_sync_2ff #(
    .WIDTH(pmic_event_pkg::DATA_W),
    .RESET_VALUE(pmic_event_pkg::RST_READ_DATA)
  ) u_live_sync (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .async_in(live_condition_in),
    .sync_out(live_sync)
  );

  level_sync_2ff #(
    .WIDTH(pmic_event_pkg::DOMAIN_PINS),
    .RESET_VALUE(pmic_event_pkg::RST_DOMAIN_PINS_N)
  ) u_domain_sync (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .async_in({off_state_reset_n_in, rtc_power_on_reset_n_in, external_reset_n_in}),
    .sync_out(domain_pins_n_sync)
  );

  // ************************************************************
  // Live condition view
  // ************************************************************
  always_comb
  begin
    live_view = live_sync & pmic_event_pkg::LIVE_FIRST_IMPL; // R9 R10 R11 R13
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    logic [pmic_event_pkg::DATA_W-1:0] hold_first;
    logic [pmic_event_pkg::DATA_W-1:0] hold_second;
    logic wr_flags_first;
    logic wr_flags_second;
    hold_first = held_bits(pmic_event_pkg::FIRST_IMPL, pmic_event_pkg::FIRST_RTC_DOMAIN,
      pmic_event_pkg::FIRST_OFF_DOMAIN, domain_pins_n_sync);
    hold_second = held_bits(pmic_event_pkg::SECOND_IMPL, pmic_event_pkg::SECOND_RTC_DOMAIN,
      pmic_event_pkg::SECOND_OFF_DOMAIN, domain_pins_n_sync);
    wr_flags_first = reg_req_in.wr && hit(reg_req_in, pmic_event_pkg::OFS_EVENT_FLAGS_FIRST);
    wr_flags_second = reg_req_in.wr && hit(reg_req_in, pmic_event_pkg::OFS_EVENT_FLAGS_SECOND);
    state_nxt = state_r;

    // Flags: set by events, cleared by a written one, forced to their defaults by a held reset domain.
    state_nxt.flags_first = flag_next(state_r.flags_first, first_event_in, wr_flags_first,
      reg_req_in.wdata, pmic_event_pkg::FIRST_IMPL,
      pmic_event_pkg::RST_EVENT_FLAGS_FIRST); // R14 R18
    state_nxt.flags_second = flag_next(state_r.flags_second, second_event_in, wr_flags_second,
      reg_req_in.wdata, pmic_event_pkg::SECOND_IMPL,
      pmic_event_pkg::RST_EVENT_FLAGS_SECOND); // R1 R2 R3 R5 R7 R14 R18

    // Masks: plain read-write on implemented bits only.
    if (reg_req_in.wr && hit(reg_req_in, pmic_event_pkg::OFS_EVENT_MASK_FIRST))
    begin
      state_nxt.mask_first = (reg_req_in.wdata & pmic_event_pkg::FIRST_IMPL)
        | (pmic_event_pkg::RST_EVENT_MASK_FIRST & ~pmic_event_pkg::FIRST_IMPL); // R8 R18
    end
    if (reg_req_in.wr && hit(reg_req_in, pmic_event_pkg::OFS_EVENT_MASK_SECOND))
    begin
      state_nxt.mask_second = (reg_req_in.wdata & pmic_event_pkg::SECOND_IMPL)
        | (pmic_event_pkg::RST_EVENT_MASK_SECOND & ~pmic_event_pkg::SECOND_IMPL); // R4 R12 R18
    end

    // A held reset domain overrides both events and writes.
    state_nxt.flags_first = (state_nxt.flags_first & ~hold_first)
      | (pmic_event_pkg::RST_EVENT_FLAGS_FIRST & hold_first); // R15 R16
    state_nxt.mask_first = (state_nxt.mask_first & ~hold_first)
      | (pmic_event_pkg::RST_EVENT_MASK_FIRST & hold_first); // R8 R15 R16
    state_nxt.flags_second = (state_nxt.flags_second & ~hold_second)
      | (pmic_event_pkg::RST_EVENT_FLAGS_SECOND & hold_second); // R1 R2 R3 R5 R7 R15 R16
    state_nxt.mask_second = (state_nxt.mask_second & ~hold_second)
      | (pmic_event_pkg::RST_EVENT_MASK_SECOND & hold_second); // R4 R6 R12 R15 R16

    // Read data is captured on a read strobe and held until the next one.
    if (reg_req_in.rd)
    begin
      case (reg_req_in.addr)
        pmic_event_pkg::OFS_EVENT_FLAGS_FIRST: state_nxt.rdata = state_r.flags_first;
        pmic_event_pkg::OFS_EVENT_MASK_FIRST: state_nxt.rdata = state_r.mask_first;
        pmic_event_pkg::OFS_LIVE_CONDITION_FIRST: state_nxt.rdata = live_view; // R13
        pmic_event_pkg::OFS_EVENT_FLAGS_SECOND: state_nxt.rdata = state_r.flags_second;
        pmic_event_pkg::OFS_EVENT_MASK_SECOND: state_nxt.rdata = state_r.mask_second;
        default: state_nxt.rdata = pmic_event_pkg::RST_READ_DATA;
      endcase
    end

    // The request follows the updated flags so it drops in the same cycle
    // as the clear becomes visible.
    state_nxt.irq = (|(state_nxt.flags_first & ~state_nxt.mask_first))
      || (|(state_nxt.flags_second & ~state_nxt.mask_second)); // R17
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      state_r.flags_first <= pmic_event_pkg::RST_EVENT_FLAGS_FIRST;
      state_r.mask_first <= pmic_event_pkg::RST_EVENT_MASK_FIRST;
      state_r.flags_second <= pmic_event_pkg::RST_EVENT_FLAGS_SECOND;
      state_r.mask_second <= pmic_event_pkg::RST_EVENT_MASK_SECOND; // R6
      state_r.rdata <= pmic_event_pkg::RST_READ_DATA;
      state_r.irq <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign reg_rdata_out = state_r.rdata;
  assign irq_out = state_r.irq;

endmodule : pmic_event_status_mask_sense

// File: testbench/pmic_event_checker_assertions.sv
module pmic_event_checker (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire pmic_event_pkg::reg_req_t reg_req_in,
  input wire logic [pmic_event_pkg::DATA_W-1:0] first_event_in,
  input wire logic [pmic_event_pkg::DATA_W-1:0] second_event_in,
  input wire logic [pmic_event_pkg::DATA_W-1:0] live_condition_in,
  input wire logic external_reset_n_in,
  input wire logic rtc_power_on_reset_n_in,
  input wire logic off_state_reset_n_in,
  input wire logic [pmic_event_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******************************
  // Quiet-time and mask-write trackers
  // ******************************
  // Domain pins pass a 2-flop synchroniser, so only a long quiet run is trusted.
  logic [2:0] pins_r;
  logic wrote_r;
  wire logic pins_hi = external_reset_n_in & rtc_power_on_reset_n_in & off_state_reset_n_in;
  wire logic ok = pins_r == 3'h7;
  wire logic rd = reg_req_in.rd;
  wire logic wr = reg_req_in.wr;
  wire logic [5:0] addr = reg_req_in.addr;
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in || !pins_hi)
      pins_r <= 3'h0;
    else if (!ok)
      pins_r <= pins_r + 3'h1;
    if (reset_in)
      wrote_r <= 1'b0;
    else if (wr && (addr == 6'h01 || addr == 6'h04))
      wrote_r <= 1'b1;
  end
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);
  a_live_follows: assert property (
    ok && rd && addr == 6'h02
    |=> reg_rdata_out == ($past(live_condition_in, 3) & pmic_event_pkg::LIVE_FIRST_IMPL))
    else $error("live view mismatch");
  a_unmapped_zero: assert property (
    ok && rd && addr > 6'h04 |=> reg_rdata_out == 24'h00_0000)
    else $error("unmapped read not zero");
  a_spare_ones: assert property (
    ok && rd && addr == 6'h04 |=> reg_rdata_out[21:17] == 5'h1f)
    else $error("unimplemented mask bits not one");
  a_rdata_holds: assert property (
    !rd |=> $stable(reg_rdata_out))
    else $error("read data changed without read");
  a_reset_quiet: assert property (
    $fell(reset_in) |-> !irq_out && reg_rdata_out == 24'h00_0000)
    else $error("outputs not quiet after reset");
  a_boot_unmasked: assert property (
    ok && !wrote_r && !wr && second_event_in[11] |=> irq_out)
    else $error("usb boot event did not interrupt");
  a_default_masked: assert property (
    ok && !wrote_r && !wr && !irq_out && !second_event_in[11] |=> !irq_out)
    else $error("masked event interrupted");
  a_irq_rise_cause: assert property (
    $rose(irq_out) |-> $past(first_event_in != 0 || second_event_in != 0 || wr))
    else $error("interrupt rose without cause");
  a_irq_fall_cause: assert property (
    $fell(irq_out) |-> $past(wr) || !ok)
    else $error("interrupt fell without clear");
endmodule : pmic_event_checker

bind pmic_event_status_mask_sense pmic_event_checker u_pmic_event_checker (.*);

// File: testbench/host_bus_model.sv
module host_bus_model (
  input wire logic clk_sys_in,
  input wire logic [pmic_event_pkg::DATA_W-1:0] rdata_in,
  output pmic_event_pkg::reg_req_t req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******************************
  // Host register access
  // ******************************
  initial req_out = '0;
  // Address and data are inverted once released and both strobes drop, so a stale request is never acted on.
  task automatic acc(input logic w, input logic [5:0] a, input logic [23:0] d,
                     output logic [23:0] q);
    @(negedge clk_sys_in);
    req_out.wr = w;
    req_out.rd = !w;
    req_out.addr = a;
    req_out.wdata = d;
    @(negedge clk_sys_in);
    q = rdata_in;
    req_out.wr = 1'b0;
    req_out.rd = 1'b0;
    req_out.addr = ~a;
    req_out.wdata = ~d;
  endtask : acc
endmodule : host_bus_model

// File: testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = pmic_event_pkg::DATA_W;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic [W-1:0] ev1 = '0;
  logic [W-1:0] ev2 = '0;
  logic [W-1:0] live = 24'hff_ffff;
  logic [2:0] pins_n = 3'h7;
  logic [W-1:0] rdata;
  logic irq_out;
  pmic_event_pkg::reg_req_t req;
  int err_total = 0;
  int num_checks = 0;
  always #4 clk_sys_in = ~clk_sys_in;
  pmic_event_status_mask_sense u_pmic_event_status_mask_sense (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .reg_req_in(req),
    .first_event_in(ev1), .second_event_in(ev2), .live_condition_in(live),
    .external_reset_n_in(pins_n[pmic_event_pkg::PIN_EXTERNAL]),
    .rtc_power_on_reset_n_in(pins_n[pmic_event_pkg::PIN_RTC]),
    .off_state_reset_n_in(pins_n[pmic_event_pkg::PIN_OFF]),
    .reg_rdata_out(rdata), .irq_out(irq_out));
  host_bus_model u_host_bus_model (.clk_sys_in(clk_sys_in), .rdata_in(rdata), .req_out(req));
  // ******************************
  // Shared tasks
  // ******************************
  task automatic close_out();
    if (err_total == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [5:0] a, input logic [W-1:0] exp);
    logic [W-1:0] q;
    u_host_bus_model.acc(1'b0, a, '0, q);
    chk(q, exp);
  endtask : rdc
  task automatic wr(input logic [5:0] a, input logic [W-1:0] d);
    logic [W-1:0] q;
    u_host_bus_model.acc(1'b1, a, d, q);
  endtask : wr
  task automatic evt(input logic [W-1:0] f, input logic [W-1:0] s);
    @(negedge clk_sys_in);
    ev1 = f;
    ev2 = s;
    @(negedge clk_sys_in);
    ev1 = '0;
    ev2 = '0;
  endtask : evt
  task automatic irqc(input logic exp);
    int n;
    n = 0;
    while (irq_out !== exp && n < 4)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    chk(W'(irq_out), W'(exp));
    if (irq_out !== exp)
      close_out();
  endtask : irqc
  // Pins are held low past the synchroniser depth so the hold really lands.
  task automatic dom(input int p);
    @(negedge clk_sys_in);
    pins_n[p] = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    pins_n[p] = 1'b1;
    repeat (5) @(negedge clk_sys_in);
  endtask : dom
  // ******************************
  // Scenarios
  // ******************************
  task automatic s_reset_vals();
    rdc(6'h00, 24'h00_0000);
    rdc(6'h01, 24'hff_ffff);
    rdc(6'h03, 24'h00_0080);
    rdc(6'h04, 24'hff_f7ff);
    wr(6'h02, 24'h00_0000);
    rdc(6'h02, 24'h19_7ff8);
    live = 24'h01_0010;
    repeat (3) @(negedge clk_sys_in);
    rdc(6'h02, 24'h01_0010);
    rdc(6'h3f, 24'h00_0000);
    irqc(1'b0);
  endtask : s_reset_vals
  task automatic s_flags();
    evt('0, 24'h01_3860);
    irqc(1'b1);
    rdc(6'h03, 24'h01_38e0);
    wr(6'h03, 24'h00_0000);
    rdc(6'h03, 24'h01_38e0);
    wr(6'h03, 24'h00_0880);
    irqc(1'b0);
    rdc(6'h03, 24'h01_3060);
    wr(6'h03, 24'hff_ffff);
    rdc(6'h03, 24'h00_0000);
  endtask : s_flags
  task automatic s_masks();
    wr(6'h04, 24'h00_0000);
    rdc(6'h04, 24'h3e_0000);
    evt('0, 24'h01_0000);
    irqc(1'b1);
    wr(6'h03, 24'h01_0000);
    irqc(1'b0);
    wr(6'h04, 24'hff_ffff);
    wr(6'h01, 24'h00_0000);
    rdc(6'h01, 24'hc6_8000);
    evt(24'h20_0000, '0);
    irqc(1'b1);
    wr(6'h00, 24'h20_0000);
    irqc(1'b0);
    wr(6'h01, 24'hff_ffff);
  endtask : s_masks
  task automatic s_domains();
    wr(6'h04, 24'h00_0000);
    evt('0, 24'h01_1120);
    dom(pmic_event_pkg::PIN_EXTERNAL);
    rdc(6'h03, 24'h00_0120);
    rdc(6'h04, 24'hff_f000);
    dom(pmic_event_pkg::PIN_OFF);
    rdc(6'h03, 24'h00_0020);
    rdc(6'h04, 24'hff_f11c);
    dom(pmic_event_pkg::PIN_RTC);
    rdc(6'h03, 24'h00_0080);
    rdc(6'h04, 24'hff_f7ff);
  endtask : s_domains
  initial
  begin
    repeat (6) @(negedge clk_sys_in);
    reset_in = 1'b0;
    repeat (4) @(negedge clk_sys_in);
    s_reset_vals();
    s_flags();
    s_masks();
    s_domains();
    close_out();
  end
endmodule : tb_top
